// File: hw/dcs_consts.vh
// constants for the drive command selector
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// register indices
`define DCS_R_JOG_SPEED 5'h00
`define DCS_R_JOG_RAMP 5'h01
`define DCS_R_STOP_POL 5'h02
`define DCS_R_MAIN_TL 5'h03
`define DCS_R_TL_REGEN 5'h04
`define DCS_R_TL_REVDRV 5'h05
`define DCS_R_TL_Q4 5'h06
`define DCS_R_TL_SECOND 5'h07
`define DCS_R_TL_ACCEL 5'h08
`define DCS_R_TL_DECEL 5'h09
`define DCS_R_TL_SOURCE 5'h0a
`define DCS_R_CONST_OUT 5'h0b
`define DCS_R_MS_COMP 5'h0c
`define DCS_R_SPD_IN_SEL 5'h0d
`define DCS_R_CTRL_MODE 5'h0e
`define DCS_R_PRESET_HI 5'h0f
`define DCS_R_PRESET_MID 5'h10
`define DCS_R_PRESET_LO 5'h11
`define DCS_R_RAMP1 5'h12
`define DCS_R_RAMP2 5'h13
`define DCS_R_RAMP3 5'h14
`define DCS_R_TERM_FUNC0 5'h15
`define DCS_R_STATUS 5'h1f
`define DCS_NUM_CFG 26
// reset values
`define DCS_RST_JOG_SPEED 16'h0096
`define DCS_RST_JOG_RAMP 16'h0005
`define DCS_RST_MAIN_TL 16'h0096
`define DCS_RST_RAMP 16'h0050
`define DCS_RST_UNSET 16'h270f
`define DCS_RST_ZERO 16'h0000
// field codes
`define DCS_UNSET 16'h270f
`define DCS_FUNC_JOG 16'h0005
`define DCS_POL_BREAK 16'h0002
`define DCS_TL_EXTERNAL 16'h0001
`define DCS_COMP_ON 16'h0001
`define DCS_SEL_OVR_A 16'h0004
`define DCS_SEL_OVR_B 16'h000e
`define DCS_MODE_SPEED 2'h0
`define DCS_MODE_TORQUE 2'h1
`define DCS_MODE_POSITION 2'h2
`define DCS_MODE_VF 2'h3
// speed sources
`define DCS_SRC_NONE 2'h0
`define DCS_SRC_JOG 2'h1
`define DCS_SRC_PRESET 2'h2
`define DCS_SRC_ANALOG 2'h3
// torque quadrants
`define DCS_Q1 2'h0
`define DCS_Q2 2'h1
`define DCS_Q3 2'h2
`define DCS_Q4 2'h3
// ramp selections
`define DCS_RAMP_1 2'h0
`define DCS_RAMP_2 2'h1
`define DCS_RAMP_3 2'h2
`define DCS_RAMP_JOG 2'h3
`endif

// File: hw/dcs_limit_pick.v
// limit level with fallback to the main level when unset
`timescale 1ns/1ns
`include "dcs_consts.vh"
module dcs_limit_pick
#(
    parameter W = 16
)
(
    levelIn,
    mainLevel,
    levelOut
);
    input wire [W-1:0] levelIn;
    input wire [W-1:0] mainLevel;
    output wire [W-1:0] levelOut;

    // unset code falls back to main level
    assign levelOut = (levelIn == `DCS_UNSET) ? mainLevel : levelIn;
endmodule

// File: hw/dcs_selector.v
// drive command selector: speed source, output stop, torque limit
// Notes on behaviour
// - jog uses jog speed, default 150, and one shared ramp time.
// - speed priority: jog, then preset multi-speed, then main analog.
// - second and third ramp selects ignored while jogging.
// - torque mode with jog selected: jog speed becomes the speed limit.
// - position mode ignores jog requests.
// - a terminal with function code 5 acts as jog select.
// - stop polarity 0 cuts on active input, 2 cuts on inactive.
// - speed mode clamps speed controller torque to selected limit.
// - limit source 0 uses parameters, 1 uses auxiliary torque input.
// - per-quadrant levels; unset code 9999 falls back to main level.
// - torque limit select input forces second limit level.
// - accel and decel limit levels ignored in position mode.
// - V/F with main limit 0 disables stall prevention.
// - limit parameters written over the bus apply as active limits.
// - constant-output style 0 selects constant-output limiting.
// - compensation 1 adds auxiliary analog to preset speeds.
// - speed input selection 4 or 14 takes compensation from main input.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "dcs_consts.vh"
module dcs_selector
#(
    parameter W = 16,
    parameter NTERM = 5
)
(
    sys_clk,
    rst,
    ce,
    regAddr,
    regWdata,
    regWrite,
    regRead,
    regRdata,
    termIn,
    forward_start_in,
    reverse_start_in,
    second_ramp_select,
    third_ramp_select,
    output_stop_in,
    torque_limit_select_in,
    preset_speed_high_in,
    preset_speed_mid_in,
    preset_speed_low_in,
    mainAnalogIn,
    auxAnalogIn,
    auxTorqueIn,
    torqueQuadrant,
    accelerating,
    decelerating,
    speedCtrlTorque,
    speedTarget,
    speedLimit,
    rampTime,
    rampSelect,
    speedSource,
    jogActive,
    outputEnable,
    torqueLimit,
    torqueClamped,
    stallPreventEnable,
    constantOutputMode
);
    input wire sys_clk;
    input wire rst;
    input wire ce;
    input wire [4:0] regAddr;
    input wire [W-1:0] regWdata;
    input wire regWrite;
    input wire regRead;
    output reg [W-1:0] regRdata;
    input wire [NTERM-1:0] termIn;
    input wire forward_start_in;
    input wire reverse_start_in;
    input wire second_ramp_select;
    input wire third_ramp_select;
    input wire output_stop_in;
    input wire torque_limit_select_in;
    input wire preset_speed_high_in;
    input wire preset_speed_mid_in;
    input wire preset_speed_low_in;
    input wire signed [W-1:0] mainAnalogIn;
    input wire signed [W-1:0] auxAnalogIn;
    input wire [W-1:0] auxTorqueIn;
    input wire [1:0] torqueQuadrant;
    input wire accelerating;
    input wire decelerating;
    input wire signed [W-1:0] speedCtrlTorque;
    output reg signed [W-1:0] speedTarget;
    output reg [W-1:0] speedLimit;
    output reg [W-1:0] rampTime;
    output reg [1:0] rampSelect;
    output reg [1:0] speedSource;
    output reg jogActive;
    output reg outputEnable;
    output reg [W-1:0] torqueLimit;
    output reg signed [W-1:0] torqueClamped;
    output reg stallPreventEnable;
    output reg constantOutputMode;

    // =====================================================
    // configuration registers
    reg [W-1:0] cfgReg [0:`DCS_NUM_CFG-1];
    integer i;

    function [W-1:0] resetValue;
        input integer idx;
        begin
            if (idx == `DCS_R_JOG_SPEED)
                resetValue = `DCS_RST_JOG_SPEED;
            else if (idx == `DCS_R_JOG_RAMP)
                resetValue = `DCS_RST_JOG_RAMP;
            else if (idx == `DCS_R_MAIN_TL)
                resetValue = `DCS_RST_MAIN_TL;
            else if (idx >= `DCS_R_TL_REGEN && idx <= `DCS_R_TL_DECEL)
                resetValue = `DCS_RST_UNSET;
            else if (idx >= `DCS_R_RAMP1 && idx <= `DCS_R_RAMP3)
                resetValue = `DCS_RST_RAMP;
            else
                resetValue = `DCS_RST_ZERO;
        end
    endfunction

    // bus writes update live limits at once
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < `DCS_NUM_CFG; i = i + 1)
                cfgReg[i] <= resetValue(i);
        end
        else if (ce && regWrite && regAddr < `DCS_NUM_CFG)
        begin
            cfgReg[regAddr] <= regWdata;
        end
    end

    wire [1:0] ctrlMode = cfgReg[`DCS_R_CTRL_MODE][1:0];
    wire [W-1:0] mainTl = cfgReg[`DCS_R_MAIN_TL];

    // =====================================================
    // jog terminal mapping
    reg jogSelect;
    integer t;
    always @*
    begin
        jogSelect = 1'b0;
        for (t = 0; t < NTERM; t = t + 1)
            if (cfgReg[`DCS_R_TERM_FUNC0 + t] == `DCS_FUNC_JOG && termIn[t])
                jogSelect = 1'b1;
    end

    wire jogValid = jogSelect && ctrlMode != `DCS_MODE_POSITION;
    wire runFwd = forward_start_in && !reverse_start_in;
    wire runRev = reverse_start_in && !forward_start_in;
    wire presetAny = preset_speed_high_in || preset_speed_mid_in ||
        preset_speed_low_in;

    // =====================================================
    // preset speed with compensation
    reg [W-1:0] presetSpeed;
    always @*
    begin
        if (preset_speed_high_in)
            presetSpeed = cfgReg[`DCS_R_PRESET_HI];
        else if (preset_speed_mid_in)
            presetSpeed = cfgReg[`DCS_R_PRESET_MID];
        else
            presetSpeed = cfgReg[`DCS_R_PRESET_LO];
    end

    wire [W-1:0] spdSel = cfgReg[`DCS_R_SPD_IN_SEL];
    wire overrideSrc = spdSel == `DCS_SEL_OVR_A ||
        spdSel == `DCS_SEL_OVR_B;
    wire signed [W-1:0] compSignal = overrideSrc ? mainAnalogIn :
        auxAnalogIn;
    wire compOn = cfgReg[`DCS_R_MS_COMP] == `DCS_COMP_ON;
    wire signed [W:0] compSum = {1'b0, presetSpeed} +
        {compSignal[W-1], compSignal};
    reg signed [W-1:0] presetComp;
    always @*
    begin
        if (!compOn)
            presetComp = $signed(presetSpeed);
        else if (compSum[W] != compSum[W-1])
            presetComp = compSum[W] ? {1'b1, {(W-1){1'b0}}} :
                {1'b0, {(W-1){1'b1}}};
        else
            presetComp = compSum[W-1:0];
    end

    // =====================================================
    // speed source priority
    reg signed [W-1:0] cmdNext;
    reg [1:0] srcNext;
    wire [W-1:0] jogSpeed = cfgReg[`DCS_R_JOG_SPEED];
    always @*
    begin
        if (jogValid)
        begin
            srcNext = `DCS_SRC_JOG;
            cmdNext = runRev ? -$signed(jogSpeed) : $signed(jogSpeed);
        end
        else if (presetAny)
        begin
            srcNext = `DCS_SRC_PRESET;
            cmdNext = presetComp;
        end
        else
        begin
            srcNext = `DCS_SRC_ANALOG;
            cmdNext = mainAnalogIn;
        end
    end

    wire running = runFwd || runRev;
    reg signed [W-1:0] speedTarget_next;
    reg [W-1:0] speedLimit_next;
    always @*
    begin
        speedTarget_next = {W{1'b0}};
        speedLimit_next = {W{1'b0}};
        if (ctrlMode == `DCS_MODE_TORQUE)
        begin
            if (jogValid)
                speedLimit_next = jogSpeed;
            else
                speedLimit_next = cmdNext[W-1] ? -cmdNext : cmdNext;
        end
        else if (running)
        begin
            speedTarget_next = cmdNext;
        end
    end

    // =====================================================
    // ramp time selection
    reg [1:0] rampSel_next;
    reg [W-1:0] rampTime_next;
    always @*
    begin
        if (jogValid)
        begin
            rampSel_next = `DCS_RAMP_JOG;
            rampTime_next = cfgReg[`DCS_R_JOG_RAMP];
        end
        else if (third_ramp_select)
        begin
            rampSel_next = `DCS_RAMP_3;
            rampTime_next = cfgReg[`DCS_R_RAMP3];
        end
        else if (second_ramp_select)
        begin
            rampSel_next = `DCS_RAMP_2;
            rampTime_next = cfgReg[`DCS_R_RAMP2];
        end
        else
        begin
            rampSel_next = `DCS_RAMP_1;
            rampTime_next = cfgReg[`DCS_R_RAMP1];
        end
    end

    // =====================================================
    // output stop polarity
    wire stopBreak = cfgReg[`DCS_R_STOP_POL] == `DCS_POL_BREAK;
    wire outputCut = stopBreak ? !output_stop_in : output_stop_in;

    // =====================================================
    // torque limit selection
    wire [W-1:0] regenTl;
    wire [W-1:0] revTl;
    wire [W-1:0] q4Tl;
    wire [W-1:0] secondTl;
    wire [W-1:0] accelTl;
    wire [W-1:0] decelTl;

    dcs_limit_pick #(.W(W)) pickRegen
    (
        .levelIn(cfgReg[`DCS_R_TL_REGEN]),
        .mainLevel(mainTl),
        .levelOut(regenTl)
    );
    dcs_limit_pick #(.W(W)) pickRev
    (
        .levelIn(cfgReg[`DCS_R_TL_REVDRV]),
        .mainLevel(mainTl),
        .levelOut(revTl)
    );
    dcs_limit_pick #(.W(W)) pickQ4
    (
        .levelIn(cfgReg[`DCS_R_TL_Q4]),
        .mainLevel(mainTl),
        .levelOut(q4Tl)
    );
    dcs_limit_pick #(.W(W)) pickSecond
    (
        .levelIn(cfgReg[`DCS_R_TL_SECOND]),
        .mainLevel(mainTl),
        .levelOut(secondTl)
    );

    wire accelSet = cfgReg[`DCS_R_TL_ACCEL] != `DCS_UNSET;
    wire decelSet = cfgReg[`DCS_R_TL_DECEL] != `DCS_UNSET;
    assign accelTl = cfgReg[`DCS_R_TL_ACCEL];
    assign decelTl = cfgReg[`DCS_R_TL_DECEL];
    wire extSource = cfgReg[`DCS_R_TL_SOURCE] == `DCS_TL_EXTERNAL;
    wire notPos = ctrlMode != `DCS_MODE_POSITION;

    reg [W-1:0] torqueLimit_next;
    always @*
    begin
        if (torque_limit_select_in)
            torqueLimit_next = secondTl;
        else if (extSource)
            torqueLimit_next = auxTorqueIn;
        else if (notPos && accelerating && accelSet)
            torqueLimit_next = accelTl;
        else if (notPos && decelerating && decelSet)
            torqueLimit_next = decelTl;
        else
        begin
            case (torqueQuadrant)
                `DCS_Q2: torqueLimit_next = regenTl;
                `DCS_Q3: torqueLimit_next = revTl;
                `DCS_Q4: torqueLimit_next = q4Tl;
                default: torqueLimit_next = mainTl;
            endcase
        end
    end

    // clamp against the limit in force this cycle
    wire [W:0] limWide = {1'b0, torqueLimit_next};
    wire [W:0] trqWide = {speedCtrlTorque[W-1], speedCtrlTorque};
    wire limBig = torqueLimit_next[W-1];
    reg signed [W-1:0] torqueClamped_next;
    always @*
    begin
        torqueClamped_next = speedCtrlTorque;
        if (ctrlMode == `DCS_MODE_SPEED && !limBig)
        begin
            if ($signed(trqWide) > $signed(limWide))
                torqueClamped_next = torqueLimit_next;
            else if ($signed(trqWide) < -$signed(limWide))
                torqueClamped_next = -$signed(torqueLimit_next);
        end
    end

    wire stallOff = ctrlMode == `DCS_MODE_VF && mainTl == {W{1'b0}};
    wire constOut = cfgReg[`DCS_R_CONST_OUT] == {W{1'b0}};

    // =====================================================
    // registered outputs, updated every enabled cycle
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            speedTarget <= {W{1'b0}};
            speedLimit <= {W{1'b0}};
            rampTime <= {W{1'b0}};
            rampSelect <= `DCS_RAMP_1;
            speedSource <= `DCS_SRC_NONE;
            jogActive <= 1'b0;
            outputEnable <= 1'b0;
            torqueLimit <= {W{1'b0}};
            torqueClamped <= {W{1'b0}};
            stallPreventEnable <= 1'b1;
            constantOutputMode <= 1'b1;
        end
        else if (ce)
        begin
            speedTarget <= speedTarget_next;
            speedLimit <= speedLimit_next;
            rampTime <= rampTime_next;
            rampSelect <= rampSel_next;
            speedSource <= srcNext;
            jogActive <= jogValid && running;
            outputEnable <= !outputCut;
            torqueLimit <= torqueLimit_next;
            torqueClamped <= torqueClamped_next;
            stallPreventEnable <= !stallOff;
            constantOutputMode <= constOut;
        end
    end

    // =====================================================
    // register read port
    wire [W-1:0] statusWord = {{(W-9){1'b0}}, constOut, !stallOff,
        outputCut, jogSelect, jogValid, rampSel_next, srcNext};
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            regRdata <= {W{1'b0}};
        else if (ce)
        begin
            if (!regRead)
                regRdata <= {W{1'b0}};
            else if (regAddr < `DCS_NUM_CFG)
                regRdata <= cfgReg[regAddr];
            else if (regAddr == `DCS_R_STATUS)
                regRdata <= statusWord;
            else
                regRdata <= {W{1'b0}};
        end
    end
endmodule

// File: bench/dcs_terminals.sv
// terminal-side model: jog select, start levels, jog speed setting
`timescale 1ns/1ns
module dcs_terminals
#(
    parameter START_SPEED = 16'h000f
)
(
    input wire sys_clk,
    input wire rst,
    input wire jogReq,
    input wire runReq,
    input wire revReq,
    input wire [15:0] jogWant,
    output wire [15:0] jogSpeedCfg,
    output reg jogSel,
    output reg fwdStart,
    output reg revStart
);
    // =====================================================
    // jog speed never below starting speed
    assign jogSpeedCfg = (jogWant < START_SPEED) ? START_SPEED : jogWant;
    always @(posedge sys_clk or posedge rst)
        if (rst)
        begin
            jogSel <= 1'b0;
            fwdStart <= 1'b0;
            revStart <= 1'b0;
        end
        else
        begin
            jogSel <= jogReq;
            fwdStart <= runReq && !revReq && (!jogReq || jogSel);
            revStart <= runReq && revReq && (!jogReq || jogSel);
        end
endmodule

// File: bench/dcs_selector_checker.sv
// port assertions for the drive command selector
`timescale 1ns/1ns
module dcs_selector_checker
#(
    parameter W = 16
)
(
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire [4:0] regAddr,
    input wire [W-1:0] regWdata,
    input wire regWrite,
    input wire output_stop_in,
    input wire torque_limit_select_in,
    input wire [W-1:0] auxTorqueIn,
    input wire [1:0] torqueQuadrant,
    input wire accelerating,
    input wire decelerating,
    input wire [1:0] rampSelect,
    input wire [1:0] speedSource,
    input wire jogActive,
    input wire outputEnable,
    input wire [W-1:0] torqueLimit,
    input wire stallPreventEnable,
    input wire constantOutputMode
);
    // =====================================================
    // shadow of the low configuration words
    reg [W-1:0] sh [0:15];
    integer i;
    always @(posedge sys_clk or posedge rst)
        if (rst)
            for (i = 0; i < 16; i = i + 1)
                sh[i] <= (i == 3) ? 16'h0096 :
                    ((i > 3 && i < 10) ? 16'h270f : 16'h0000);
        else if (ce && regWrite && regAddr < 5'h10)
            sh[regAddr[3:0]] <= regWdata;
    wire [1:0] mode = sh[14][1:0];
    wire polBrk = sh[2] == 16'h0002;
    wire extSrc = sh[10] == 16'h0001;
    wire [W-1:0] secLim = (sh[7] == 16'h270f) ? sh[3] : sh[7];
    wire [W-1:0] regenLim = (sh[4] == 16'h270f) ? sh[3] : sh[4];
    wire stallOff = mode == 2'h3 && sh[3] == 16'h0000;
    wire cstOut = sh[11] == 16'h0000;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_jog_on;
        ce && mode == 2'h0 ##1 jogActive;
    endsequence
    sequence s_tl_held;
        (torque_limit_select_in && ce) [*2];
    endsequence
    a_stop_level: assert property (ce |=> outputEnable ==
        ($past(polBrk) ? $past(output_stop_in) : !$past(output_stop_in)))
        else $error("output enable does not follow stop input");
    a_jog_ramp: assert property (s_jog_on |->
        speedSource == 2'h1 && rampSelect == 2'h3)
        else $error("jog without jog source or ramp");
    a_no_pos_jog: assert property (ce && mode == 2'h2 |=> !jogActive)
        else $error("jog active in position mode");
    a_tl_second: assert property (s_tl_held |=>
        torqueLimit == $past(secLim))
        else $error("second limit not applied");
    a_tl_external: assert property (ce && !torque_limit_select_in && extSrc
        |=> torqueLimit == $past(auxTorqueIn))
        else $error("external limit not applied");
    a_tl_regen: assert property (ce && !torque_limit_select_in && !extSrc
        && !accelerating && !decelerating && torqueQuadrant == 2'h1
        |=> torqueLimit == $past(regenLim))
        else $error("regeneration limit not applied");
    a_stall_off: assert property (ce |=>
        stallPreventEnable == !$past(stallOff))
        else $error("stall prevention enable wrong");
    a_const_out: assert property (ce |=>
        constantOutputMode == $past(cstOut))
        else $error("constant output mode wrong");
endmodule
bind dcs_selector dcs_selector_checker #(.W(W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite),
    .output_stop_in(output_stop_in),
    .torque_limit_select_in(torque_limit_select_in),
    .auxTorqueIn(auxTorqueIn), .torqueQuadrant(torqueQuadrant),
    .accelerating(accelerating), .decelerating(decelerating),
    .rampSelect(rampSelect), .speedSource(speedSource),
    .jogActive(jogActive), .outputEnable(outputEnable),
    .torqueLimit(torqueLimit), .stallPreventEnable(stallPreventEnable),
    .constantOutputMode(constantOutputMode));

// File: bench/tb.sv
// self-checking bench for the drive command selector
`timescale 1ns/1ns
module tb;
    reg sys_clk = 0;
    reg rst = 1;
    reg ce = 1;
    reg [4:0] regAddr = 0;
    reg [15:0] regWdata = 0;
    reg regWrite = 0;
    reg regRead = 0;
    reg stopIn = 0;
    reg tlSel = 0;
    reg accel = 0;
    reg decel = 0;
    reg ramp2 = 0;
    reg ramp3 = 0;
    reg [2:0] preset = 0;
    reg [1:0] quad = 0;
    reg jogReq = 0;
    reg runReq = 0;
    reg revReq = 0;
    reg [15:0] mainIn = 0;
    reg [15:0] auxIn = 0;
    reg [15:0] auxTq = 0;
    reg [15:0] ctrlTq = 0;
    reg [3:0] termHi = 0;
    reg [31:0] r;
    reg [15:0] cfg [0:25];
    wire jogSel;
    wire fwd;
    wire rev;
    wire jogAct;
    wire outEn;
    wire stallEn;
    wire cstMode;
    wire [1:0] rSel;
    wire [1:0] src;
    wire [15:0] jogCfg, rdata, target, spdLim, rTime, tqLim, tqClamp;
    integer num_errors = 0;
    integer tests_run = 0;
    integer seed = 32'h297ec65d;
    integer cyc = 0;
    integer i;
    integer k;
    // =====================================================
    // far side and design
    dcs_terminals term (.sys_clk(sys_clk), .rst(rst), .jogReq(jogReq),
        .runReq(runReq), .revReq(revReq), .jogWant(16'h0096),
        .jogSpeedCfg(jogCfg), .jogSel(jogSel), .fwdStart(fwd),
        .revStart(rev));
    dcs_selector dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(rdata), .termIn({termHi, jogSel}),
        .forward_start_in(fwd), .reverse_start_in(rev),
        .second_ramp_select(ramp2), .third_ramp_select(ramp3),
        .output_stop_in(stopIn), .torque_limit_select_in(tlSel),
        .preset_speed_high_in(preset[2]), .preset_speed_mid_in(preset[1]),
        .preset_speed_low_in(preset[0]), .mainAnalogIn(mainIn),
        .auxAnalogIn(auxIn), .auxTorqueIn(auxTq), .torqueQuadrant(quad),
        .accelerating(accel), .decelerating(decel), .speedCtrlTorque(ctrlTq),
        .speedTarget(target), .speedLimit(spdLim), .rampTime(rTime),
        .rampSelect(rSel), .speedSource(src), .jogActive(jogAct),
        .outputEnable(outEn), .torqueLimit(tqLim), .torqueClamped(tqClamp),
        .stallPreventEnable(stallEn), .constantOutputMode(cstMode));
    function [15:0] rstVal(input integer a);
        rstVal = (a == 0 || a == 3) ? 16'h0096 : (a == 1) ? 16'h0005 :
            (a > 3 && a < 10) ? 16'h270f :
            (a > 17 && a < 21) ? 16'h0050 : 16'h0000;
    endfunction
    function [15:0] fb(input [15:0] v);
        fb = (v == 16'h270f) ? cfg[3] : v;
    endfunction
    function [15:0] expTl();
        if (tlSel)
            expTl = fb(cfg[7]);
        else if (cfg[10] == 16'h0001)
            expTl = auxTq;
        else if (cfg[14] != 2 && accel && cfg[8] != 16'h270f)
            expTl = cfg[8];
        else if (cfg[14] != 2 && decel && cfg[9] != 16'h270f)
            expTl = cfg[9];
        else
            expTl = (quad == 0) ? cfg[3] : fb(cfg[3 + quad]);
    endfunction
    function [15:0] expCl(input [15:0] t, input [15:0] l);
        if (l >= 16'h8000 || $signed(t) <= $signed(l) && $signed(t) >= -$signed(l))
            expCl = t;
        else
            expCl = ($signed(t) > 0) ? l : -l;
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        @(posedge sys_clk);
        regWrite <= 1;
        regAddr <= a;
        regWdata <= d;
        if (a < 26)
            cfg[a] = d;
        @(posedge sys_clk);
        regWrite <= 0;
    endtask
    task rd(input [4:0] a, input [15:0] x);
        @(posedge sys_clk);
        regRead <= 1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 0;
        #1;
        chk(rdata, x);
    endtask
    task settle(input integer n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end
    // =====================================================
    // main sequence
    initial
    begin
        for (i = 0; i < 26; i = i + 1)
            cfg[i] = rstVal(i);
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        for (i = 0; i < 27; i = i + 1)
            rd(i, rstVal(i));
        rd(31, 16'h0183);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(2, {14'h0, i[1], 1'b0});
            @(posedge sys_clk);
            stopIn <= i[0];
            settle(2);
            chk({15'h0, outEn}, {15'h0, ~(i[0] ^ i[1])});
        end
        @(posedge sys_clk);
        ce <= 0;
        stopIn <= 0;
        settle(2);
        chk({15'h0, outEn}, 16'h0001);
        @(posedge sys_clk);
        ce <= 1;
        wr(21, 16'h0005);
        wr(0, jogCfg);
        wr(15, 16'h03e8);
        @(posedge sys_clk);
        ramp2 <= 1;
        ramp3 <= 1;
        preset <= 3'b111;
        jogReq <= 1;
        runReq <= 1;
        settle(4);
        chk({14'h0, src}, 16'h0001);
        chk(target, 16'h0096);
        chk({14'h0, rSel}, 16'h0003);
        chk(rTime, 16'h0005);
        chk({15'h0, jogAct}, 16'h0001);
        @(posedge sys_clk);
        revReq <= 1;
        settle(4);
        chk(target, 16'hff6a);
        @(posedge sys_clk);
        revReq <= 0;
        jogReq <= 0;
        settle(4);
        chk(target, 16'h03e8);
        chk({14'h0, rSel}, 16'h0002);
        chk(rTime, 16'h0050);
        r = $random(seed);
        @(posedge sys_clk);
        preset <= 0;
        mainIn <= r[15:0];
        settle(2);
        chk({14'h0, src}, 16'h0003);
        chk(target, mainIn);
        wr(14, 16'h0001);
        @(posedge sys_clk);
        jogReq <= 1;
        settle(4);
        chk(spdLim, 16'h0096);
        wr(14, 16'h0002);
        settle(2);
        chk({15'h0, jogAct}, 16'h0000);
        chk({14'h0, src}, 16'h0003);
        r = $random(seed);
        @(posedge sys_clk);
        jogReq <= 0;
        preset <= 3'b010;
        auxIn <= {{6{r[9]}}, r[9:0]};
        mainIn <= {{6{r[25]}}, r[25:16]};
        wr(14, 16'h0000);
        wr(16, 16'h01f4);
        wr(12, 16'h0001);
        for (k = 0; k < 3; k = k + 1)
        begin
            wr(13, (k == 0) ? 16'h0000 : (k == 1) ? 16'h0004 : 16'h000e);
            settle(2);
            chk(target, 16'h01f4 + ((k > 0) ? mainIn : auxIn));
        end
        wr(12, 16'h0000);
        settle(2);
        chk(target, 16'h01f4);
        wr(14, 16'h0003);
        wr(3, 16'h0000);
        settle(2);
        chk({15'h0, stallEn}, 16'h0000);
        wr(3, 16'h0096);
        wr(11, 16'h0001);
        settle(2);
        chk({15'h0, stallEn}, 16'h0001);
        chk({15'h0, cstMode}, 16'h0000);
        wr(11, 16'h0000);
        settle(2);
        chk({15'h0, cstMode}, 16'h0001);
        for (i = 0; i < 64; i = i + 1)
        begin
            if (i % 8 == 0)
            begin
                for (k = 4; k < 10; k = k + 1)
                    wr(k, ($random(seed) & 3) ? {$random(seed)} % 401 : 16'h270f);
                wr(10, {15'h0, i[3]});
                wr(14, {14'h0, i[4], 1'b0});
            end
            r = $random(seed);
            @(posedge sys_clk);
            tlSel <= r[1:0] == 2'h0;
            accel <= r[2];
            decel <= r[3];
            quad <= r[5:4];
            auxTq <= {7'h0, r[14:6]};
            ctrlTq <= r[31:16];
            settle(3);
            chk(tqLim, expTl());
            if (cfg[14] == 0)
                chk(tqClamp, expCl(ctrlTq, expTl()));
        end
        end_of_test;
    end
endmodule
